// >>> verilog/rcu_ctrl.sv
// module: receive unit control state machine
`timescale 1ns/10ps

// Behaviour
// - status bits 5:2 give idle 0000, no resources 0010, suspended 0001, ready 0100
// - reset leaves the unit idle, without descriptors, discarding every frame
// - end-of-list descriptor done: go no-resources, discard and count discarded frames
// - suspend descriptor done: go suspended, discard frames despite free descriptors
// - frames are stored into descriptors only in the ready state
// - start with no frame arriving: clear pending, load pointer, maybe enter ready
// - start during a frame: save pointer, set pending, act when frame completes
// - resume while suspended and not discarding: go ready and set up descriptor
// - resume while suspended and discarding: remember it, act at frame completion
// - resume is ignored in every state except suspended
// - abort raises receiver not ready interrupt only from the ready state
// - abort from any state halts receive DMA, discards data, goes idle
// - a frame arriving means actively receiving, whatever the unit state
// - every frame completed in the ready state raises an interrupt request
// - commands are analysed only after the command unit hands them over
// - at acceptance read command, take initial action, then clear command byte
// - status word updated on acceptance, state change and frame completion
// - command byte may be cleared before the new status is written
// - acknowledge clears pending bits at once; line released when none remain
module rcu_ctrl
  import rcu_pkg::*;
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // command hand-over from the command unit
  input  wire logic              cmd_valid,
  input  wire rcu_cmd_t          cmd,
  output logic                   cmd_clear_q,
  // frame arrival and descriptor results
  input  wire rcu_frame_t        frame,
  // receive DMA control
  output logic                   store_q,
  output logic                   discard_q,
  output logic                   rx_active_q,
  output logic                   setup_q,
  output logic                   release_q,
  output logic                   dma_halt_q,
  output logic                   discard_count_q,
  output logic      [PTR_W-1:0]  next_ptr_q,
  // interrupts
  input  wire logic [IRQ_W-1:0]  ack,
  output logic      [IRQ_W-1:0]  irq_pend_q,
  output logic                   interrupt_line_n,
  // status word
  output logic      [STAT_W-1:0] status_word_q,
  output logic                   status_wr_q
);

  rcu_state_t       state_q;
  rcu_state_t       state_d;
  logic             start_pend_q;
  logic             start_pend_d;
  logic             resume_pend_q;
  logic             resume_pend_d;
  logic [PTR_W-1:0] ptr_d;
  logic             setup_d;
  logic             release_d;
  logic             halt_d;
  logic             dcount_d;
  logic             rnr_d;
  logic             fr_d;
  logic             upd_q;
  logic             upd_d;
  logic [IRQ_W-1:0] irq_set;

  // command decode
  wire cmd_nonzero = (cmd.code != CMD_NONE);
  // hold off while the previous clear is still visible and at frame completion
  wire accept      = cmd_valid && cmd_nonzero && !cmd_clear_q && !frame.done;
  wire is_start    = accept && (cmd.code == CMD_START);
  wire is_resume   = accept && (cmd.code == CMD_RESUME);
  wire is_abort    = accept && (cmd.code == CMD_ABORT);
  wire is_ready    = (state_q == ST_READY);
  wire is_susp     = (state_q == ST_SUSP);
  wire pend_any    = start_pend_q || resume_pend_q;
  wire complete    = frame.done && !accept;

  always_comb begin
    state_d       = state_q;
    start_pend_d  = start_pend_q;
    resume_pend_d = resume_pend_q;
    ptr_d         = next_ptr_q;
    setup_d       = 1'b0;
    release_d     = 1'b0;
    halt_d        = 1'b0;
    dcount_d      = 1'b0;
    rnr_d         = 1'b0;
    fr_d          = 1'b0;
    if (is_start) begin
      ptr_d = cmd.offset;
      if (frame.active) begin
        start_pend_d = 1'b1;
      end else begin
        start_pend_d = 1'b0;
        if (!is_ready && !frame.data_wr) begin
          state_d   = ST_READY;
          setup_d   = 1'b1;
          release_d = 1'b1;
        end
      end
    end else if (is_resume) begin
      if (is_susp) begin
        if (frame.active) begin
          resume_pend_d = 1'b1;
        end else begin
          state_d = ST_READY;
          setup_d = 1'b1;
        end
      end
    end else if (is_abort) begin
      rnr_d         = is_ready;
      halt_d        = 1'b1;
      state_d       = ST_IDLE;
      start_pend_d  = 1'b0;
      resume_pend_d = 1'b0;
    end else if (complete) begin
      case (state_q)
        ST_READY: begin
          fr_d = 1'b1;
          if (frame.el) begin
            state_d = ST_NORES;
          end else if (frame.susp) begin
            state_d = ST_SUSP;
          end else begin
            setup_d = 1'b1;
          end
        end
        ST_NORES: begin
          dcount_d = 1'b1;
        end
        default: begin
        end
      endcase
      if (pend_any) begin
        state_d       = ST_READY;
        setup_d       = 1'b1;
        start_pend_d  = 1'b0;
        resume_pend_d = 1'b0;
      end
    end
  end

  // status refresh events
  assign upd_d   = accept || (state_d != state_q) || frame.done;
  assign irq_set = {rnr_d, fr_d};

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q         <= ST_IDLE;
      start_pend_q    <= 1'b0;
      resume_pend_q   <= 1'b0;
      next_ptr_q      <= '0;
      cmd_clear_q     <= 1'b0;
      store_q         <= 1'b0;
      discard_q       <= 1'b1;
      rx_active_q     <= 1'b0;
      setup_q         <= 1'b0;
      release_q       <= 1'b0;
      dma_halt_q      <= 1'b0;
      discard_count_q <= 1'b0;
      upd_q           <= 1'b0;
    end else begin
      state_q         <= state_d;
      start_pend_q    <= start_pend_d;
      resume_pend_q   <= resume_pend_d;
      next_ptr_q      <= ptr_d;
      cmd_clear_q     <= accept;
      store_q         <= (state_d == ST_READY);
      discard_q       <= (state_d != ST_READY);
      rx_active_q     <= frame.active;
      setup_q         <= setup_d;
      release_q       <= release_d;
      dma_halt_q      <= halt_d;
      discard_count_q <= dcount_d;
      upd_q           <= upd_d;
    end
  end

  rcu_irq u_irq (
    .clock            (clock),
    .rst_n            (rst_n),
    .set_req          (irq_set),
    .ack              (ack),
    .pend_q           (irq_pend_q),
    .interrupt_line_n (interrupt_line_n)
  );

  rcu_status u_status (
    .clock         (clock),
    .rst_n         (rst_n),
    .upd           (upd_q),
    .ru_code       (rcu_state_code(state_q)),
    .pend          (irq_pend_q),
    .status_word_q (status_word_q),
    .status_wr_q   (status_wr_q)
  );

  property p_abort_idle;
    @(posedge clock) disable iff (!rst_n)
      is_abort |=> (state_q == ST_IDLE) && dma_halt_q && discard_q;
  endproperty
  a_abort_idle: assert property (p_abort_idle)
    else $error("abort did not halt DMA and go idle");

  property p_abort_rnr;
    @(posedge clock) disable iff (!rst_n)
      (is_abort && is_ready) |=> irq_pend_q[IRQ_RNR] ##1 !interrupt_line_n;
  endproperty
  a_abort_rnr: assert property (p_abort_rnr)
    else $error("abort from ready raised no receiver not ready request");

  property p_resume_ignored;
    @(posedge clock) disable iff (!rst_n)
      (is_resume && !is_susp) |=> $stable(state_q) && !setup_q;
  endproperty
  a_resume_ignored: assert property (p_resume_ignored)
    else $error("resume acted outside the suspended state");

  property p_resume_now;
    @(posedge clock) disable iff (!rst_n)
      (is_resume && is_susp && !frame.active) |=> (state_q == ST_READY) && setup_q;
  endproperty
  a_resume_now: assert property (p_resume_now)
    else $error("resume while suspended did not go ready");

  property p_el_nores;
    @(posedge clock) disable iff (!rst_n)
      (complete && is_ready && frame.el && !pend_any) |=> (state_q == ST_NORES) && !store_q;
  endproperty
  a_el_nores: assert property (p_el_nores)
    else $error("end of list descriptor did not lead to no resources");

  property p_susp;
    @(posedge clock) disable iff (!rst_n)
      (complete && is_ready && !frame.el && frame.susp && !pend_any)
      |=> (state_q == ST_SUSP) && discard_q;
  endproperty
  a_susp: assert property (p_susp)
    else $error("suspend descriptor did not suspend the unit");

  property p_start_late;
    @(posedge clock) disable iff (!rst_n)
      (is_start && frame.active) |=> start_pend_q && $stable(state_q);
  endproperty
  a_start_late: assert property (p_start_late)
    else $error("start during a frame was not deferred");

  property p_clear_then_status;
    @(posedge clock) disable iff (!rst_n)
      accept |=> cmd_clear_q ##1 (status_wr_q && !cmd_clear_q);
  endproperty
  a_clear_then_status: assert property (p_clear_then_status)
    else $error("command byte clear and status write out of order");

  property p_frame_irq;
    @(posedge clock) disable iff (!rst_n)
      (complete && is_ready) |=> irq_pend_q[IRQ_FR];
  endproperty
  a_frame_irq: assert property (p_frame_irq)
    else $error("received frame raised no interrupt request");

  property p_rx_active;
    @(posedge clock) disable iff (!rst_n)
      frame.active |=> rx_active_q;
  endproperty
  a_rx_active: assert property (p_rx_active)
    else $error("arriving frame not flagged as actively receiving");

  property p_store_ready;
    @(posedge clock) disable iff (!rst_n)
      store_q |-> (state_q == ST_READY) && !discard_q;
  endproperty
  a_store_ready: assert property (p_store_ready)
    else $error("storing outside the ready state");

  property p_status_code;
    @(posedge clock) disable iff (!rst_n)
      status_wr_q |-> status_word_q[STAT_RU_MSB:STAT_RU_LSB] == rcu_state_code($past(state_q));
  endproperty
  a_status_code: assert property (p_status_code)
    else $error("status word holds a wrong unit state code");

endmodule

// >>> verilog/rcu_pkg.sv
// package: receive unit control constants, types and state encoding
package rcu_pkg;

  // receive unit command field
  localparam int          CMD_W        = 3;
  localparam logic [2:0]  CMD_NONE     = 3'h0;
  localparam logic [2:0]  CMD_START    = 3'h1;
  localparam logic [2:0]  CMD_RESUME   = 3'h2;
  localparam logic [2:0]  CMD_ABORT    = 3'h4;
  localparam logic [2:0]  CMD_LOAD_HEADER_SIZE_CMD = 3'h5;

  // descriptor pointer width
  localparam int          PTR_W        = 32;

  // status word layout
  localparam int          STAT_W       = 16;
  localparam int          STAT_RU_LSB  = 2;
  localparam int          STAT_RU_MSB  = 5;
  localparam int          STAT_FR_BIT  = 15;
  localparam int          STAT_RNR_BIT = 12;
  localparam logic [15:0] STAT_RST     = 16'h0000;

  // receive unit state codes in the status word
  localparam logic [3:0]  RU_IDLE_CODE  = 4'h0;
  localparam logic [3:0]  RU_NORES_CODE = 4'h2;
  localparam logic [3:0]  RU_SUSP_CODE  = 4'h1;
  localparam logic [3:0]  RU_READY_CODE = 4'h4;

  // pending interrupt bit positions
  localparam int          IRQ_W        = 2;
  localparam int          IRQ_FR       = 0;
  localparam int          IRQ_RNR      = 1;
  localparam logic [1:0]  IRQ_RST      = 2'h0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_NORES,
    ST_SUSP,
    ST_READY
  } rcu_state_t;

  typedef struct packed {
    logic [CMD_W-1:0] code;
    logic [PTR_W-1:0] offset;
  } rcu_cmd_t;

  typedef struct packed {
    logic active;
    logic done;
    logic data_wr;
    logic el;
    logic susp;
  } rcu_frame_t;

  function automatic logic [3:0] rcu_state_code(input rcu_state_t s);
    case (s)
      ST_IDLE:  rcu_state_code = RU_IDLE_CODE;
      ST_NORES: rcu_state_code = RU_NORES_CODE;
      ST_SUSP:  rcu_state_code = RU_SUSP_CODE;
      ST_READY: rcu_state_code = RU_READY_CODE;
      default:  rcu_state_code = RU_IDLE_CODE;
    endcase
  endfunction

endpackage

// >>> verilog/rcu_irq.sv
// module: pending interrupt bits, acknowledge and interrupt line
`timescale 1ns/10ps
module rcu_irq
  import rcu_pkg::*;
(
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // events and acknowledge
  input  wire logic [IRQ_W-1:0] set_req,
  input  wire logic [IRQ_W-1:0] ack,
  // state
  output logic      [IRQ_W-1:0] pend_q,
  output logic                  interrupt_line_n
);

  logic [IRQ_W-1:0] pend_d;

  // set wins over an acknowledge in the same cycle
  assign pend_d = (pend_q & ~ack) | set_req;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pend_q           <= IRQ_RST;
      interrupt_line_n <= 1'b1;
    end else begin
      pend_q           <= pend_d;
      interrupt_line_n <= ~(|pend_d);
    end
  end

  property p_line_release;
    @(posedge clock) disable iff (!rst_n)
      (pend_q != IRQ_RST) ##1 ((pend_q & ~$past(ack)) == IRQ_RST && $past(set_req) == IRQ_RST)
      |-> interrupt_line_n;
  endproperty
  a_line_release: assert property (p_line_release)
    else $error("interrupt line still asserted with no pending bits");

endmodule

// >>> verilog/rcu_status.sv
// module: status word image with delayed write strobe
`timescale 1ns/10ps
module rcu_status
  import rcu_pkg::*;
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // update request and sources
  input  wire logic              upd,
  input  wire logic [3:0]        ru_code,
  input  wire logic [IRQ_W-1:0]  pend,
  // status image
  output logic      [STAT_W-1:0] status_word_q,
  output logic                   status_wr_q
);

  logic [STAT_W-1:0] image;

  always_comb begin
    image                           = STAT_RST;
    image[STAT_RU_MSB:STAT_RU_LSB]  = ru_code;
    image[STAT_FR_BIT]              = pend[IRQ_FR];
    image[STAT_RNR_BIT]             = pend[IRQ_RNR];
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      status_word_q <= STAT_RST;
      status_wr_q   <= 1'b0;
    end else begin
      status_wr_q <= upd;
      if (upd) begin
        status_word_q <= image;
      end
    end
  end

endmodule

// >>> bench/rcu_host_model.sv
// host software model: hands receive commands over and waits for the clear
`timescale 1ns/10ps
module rcu_host_model
  import rcu_pkg::*;
(
  // clock
  input  wire logic     clock,
  // requests from the bench
  input  wire logic     req,
  input  wire rcu_cmd_t req_cmd,
  // command hand-over
  output logic          cmd_valid,
  output rcu_cmd_t      cmd,
  input  wire logic     cmd_clear_q
);
  logic busy;

  initial begin
    cmd_valid = 1'b0;
    cmd       = '0;
    busy      = 1'b0;
  end

  always @(negedge clock) begin
    // a zero field is never taken, so such a write is simply dropped
    if (cmd_valid && (cmd_clear_q || cmd.code == CMD_NONE)) begin
      // released word no longer shows the old command
      cmd_valid <= 1'b0;
      cmd       <= ~cmd;
      busy      <= 1'b0;
    end else if (req && !busy) begin
      // one receive command per write, nothing for the command unit with it
      cmd_valid <= 1'b1;
      cmd       <= req_cmd;
      busy      <= 1'b1;
    end
  end
endmodule

// >>> bench/rcu_ctrl_tb_top.sv
// self-checking bench of the receive unit control block
`timescale 1ns/10ps
module rcu_ctrl_tb_top import rcu_pkg::*; ;
  logic              clock, rst_n, req, cmd_valid, cmd_clear_q, store_q, discard_q;
  logic              rx_active_q, setup_q, release_q, dma_halt_q, discard_count_q;
  logic              interrupt_line_n, status_wr_q, sp, rp, xs, xr, xh, xc;
  logic [PTR_W-1:0]  next_ptr_q, xp, rnd;
  logic [IRQ_W-1:0]  ack, irq_pend_q, ep;
  logic [STAT_W-1:0] status_word_q;
  rcu_cmd_t          rq, cmd;
  rcu_frame_t        frame;
  rcu_state_t        es;
  int                n_errors, n_compared;

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  rcu_host_model host_u (.clock, .req, .req_cmd(rq), .cmd_valid, .cmd, .cmd_clear_q);
  rcu_ctrl dut_u (.clock, .rst_n, .cmd_valid, .cmd, .cmd_clear_q, .frame, .store_q,
    .discard_q, .rx_active_q, .setup_q, .release_q, .dma_halt_q, .discard_count_q,
    .next_ptr_q, .ack, .irq_pend_q, .interrupt_line_n, .status_word_q, .status_wr_q);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [3:0] ecode(input rcu_state_t s);
    case (s)
      ST_IDLE:  ecode = 4'h0;
      ST_NORES: ecode = 4'h2;
      ST_SUSP:  ecode = 4'h1;
      default:  ecode = 4'h4;
    endcase
  endfunction

  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  // acknowledge everything so each operation starts with no pending bit
  task automatic clr();
    @(negedge clock);
    ack <= 2'h3;
    @(negedge clock);
    ack <= 2'h0;
    ep = 2'h0;
    {xs, xr, xh, xc} = 4'h0;
  endtask

  task automatic post(input logic fin);
    chk(setup_q, xs);
    chk(release_q, xr);
    chk(dma_halt_q, xh);
    chk(discard_count_q, xc);
    chk(store_q, es == ST_READY);
    chk(discard_q, es != ST_READY);
    chk(irq_pend_q, ep);
    chk(next_ptr_q, xp);
    @(negedge clock);
    if (fin) frame <= '0;
    @(posedge clock);
    #1;
    chk(cmd_clear_q, 1'b0);
    chk(status_wr_q, 1'b1);
    chk(status_word_q[5:2], ecode(es));
    chk(status_word_q, {ep[0], 2'h0, ep[1], 6'h0, ecode(es), 2'h0});
    chk(interrupt_line_n, ep == 2'h0);
  endtask

  task automatic do_cmd(input logic [2:0] c, input logic [31:0] off, input logic act, dw);
    int i;
    clr();
    frame.active <= act;
    frame.data_wr <= dw;
    req <= 1'b1;
    rq <= '{code: c, offset: off};
    @(negedge clock);
    req <= 1'b0;
    for (i = 0; i < 8 && cmd_clear_q !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    if (cmd_clear_q !== 1'b1) begin
      n_errors++;
      stop_test();
    end
    case (c)
      CMD_START: begin
        xp = off;
        sp = act;
        if (!act && es != ST_READY && !dw) begin
          es = ST_READY;
          {xs, xr} = 2'h3;
        end
      end
      CMD_RESUME: begin
        if (es == ST_SUSP && act) rp = 1'b1;
        else if (es == ST_SUSP) begin
          es = ST_READY;
          xs = 1'b1;
        end
      end
      CMD_ABORT: begin
        xh = 1'b1;
        ep[1] = es == ST_READY;
        es = ST_IDLE;
        {sp, rp} = 2'h0;
      end
      default: ;
    endcase
    post(1'b0);
  endtask

  task automatic do_frame(input logic el, su);
    clr();
    frame.active <= 1'b1;
    @(negedge clock);
    frame <= '{active: 1'b1, done: 1'b1, data_wr: 1'b0, el: el, susp: su};
    if (es == ST_READY) begin
      ep[0] = 1'b1;
      if (el) es = ST_NORES;
      else if (su) es = ST_SUSP;
      else xs = 1'b1;
    end else xc = es == ST_NORES;
    // a deferred start or resume takes over once the frame is done
    if (sp | rp) begin
      es = ST_READY;
      xs = 1'b1;
      {sp, rp} = 2'h0;
    end
    @(posedge clock);
    #1;
    chk(rx_active_q, 1'b1);
    post(1'b1);
  endtask

  initial begin
    rst_n = 1'b0;
    req = 1'b0;
    rq = '0;
    frame = '0;
    ack = '0;
    rnd = 32'h85934707;
    n_errors = 0;
    n_compared = 0;
    es = ST_IDLE;
    {sp, rp, ep, xp} = '0;
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    @(posedge clock);
    #1;
    chk(discard_q, 1'b1);
    chk(interrupt_line_n, 1'b1);
    chk(status_word_q, 16'h0);
    chk(next_ptr_q, 32'h0);
    $display("test reset done");
    for (int k = 0; k < 60; k++) begin
      rnd = lfsr(rnd);
      case (rnd[1:0])
        2'h0: do_cmd(CMD_START, rnd, 1'b0, rnd[2] & rnd[5]);
        2'h1: do_cmd(CMD_RESUME, rnd, 1'b0, 1'b0);
        2'h2: do_cmd(CMD_ABORT, rnd, 1'b0, 1'b0);
        default: do_frame(rnd[3], rnd[4] & ~rnd[3]);
      endcase
    end
    $display("test random done");
    @(negedge clock);
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    es = ST_IDLE;
    {sp, rp, ep, xp} = '0;
    @(posedge clock);
    #1;
    chk(discard_q, 1'b1);
    chk(store_q, 1'b0);
    chk(irq_pend_q, 2'h0);
    chk(next_ptr_q, 32'h0);
    chk(status_word_q, 16'h0);
    $display("test mid reset done");
    do_cmd(CMD_ABORT, xp, 1'b0, 1'b0);
    do_cmd(CMD_START, ~rnd, 1'b1, 1'b0);
    do_frame(1'b0, 1'b0);
    do_frame(1'b1, 1'b0);
    @(negedge clock);
    ack <= 2'h2;
    @(negedge clock);
    ack <= 2'h0;
    @(posedge clock);
    #1;
    chk(irq_pend_q, 2'h1);
    chk(interrupt_line_n, 1'b0);
    @(negedge clock);
    ack <= 2'h1;
    @(negedge clock);
    ack <= 2'h0;
    @(posedge clock);
    #1;
    chk(irq_pend_q, 2'h0);
    chk(interrupt_line_n, 1'b1);
    do_frame(1'b0, 1'b0);
    do_cmd(CMD_START, rnd, 1'b0, 1'b0);
    do_frame(1'b0, 1'b1);
    do_frame(1'b0, 1'b0);
    do_cmd(CMD_RESUME, xp, 1'b1, 1'b0);
    do_frame(1'b0, 1'b0);
    do_cmd(CMD_RESUME, xp, 1'b0, 1'b0);
    do_cmd(CMD_ABORT, xp, 1'b0, 1'b0);
    do_cmd(CMD_START, lfsr(rnd), 1'b0, 1'b1);
    $display("test corners done");
    do_cmd(3'h3, xp, 1'b0, 1'b0);
    do_cmd(CMD_LOAD_HEADER_SIZE_CMD, xp, 1'b0, 1'b0);
    do_cmd(3'h6, xp, 1'b0, 1'b0);
    do_cmd(3'h7, xp, 1'b0, 1'b0);
    clr();
    req <= 1'b1;
    rq <= '{code: CMD_NONE, offset: ~xp};
    @(negedge clock);
    req <= 1'b0;
    repeat (3) begin
      @(posedge clock);
      #1;
      chk({cmd_clear_q, status_wr_q, setup_q}, 3'h0);
    end
    chk(next_ptr_q, xp);
    $display("test unused codes done");
    stop_test();
  end
endmodule
